/* src/stc_top.sv */
`timescale 1ns/1ps
module stc_top
  import stc_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cache_ram_clock_bypass,
  input wire logic [STC_REGIONS-1:0] region_clock_disable,
  input wire logic ram_select_hold,
  input wire logic multicycle_ram_hold,
  input wire logic reset_disable,
  input wire logic scan_shift_enable,
  input wire logic scan_mode_select,
  input wire logic [STC_REGIONS-1:0] region_clock_request,
  input wire logic ram_req,
  input wire logic [ADDR_W-1:0] ram_set_addr_in,
  input wire logic [DATA_W-1:0] ram_wdata_in,
  output logic ram_clock_follow_main,
  output logic [STC_REGIONS-1:0] region_clock_en,
  output logic internal_rst_n,
  output logic ram_clock_en,
  output logic ram_chip_select,
  output logic [ADDR_W-1:0] ram_set_addr,
  output logic [DATA_W-1:0] ram_wdata,
  output logic ram_busy
);
  // elaboration checks: widths and the layout the status word can carry
  if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 1024) begin : g_width_check
    $error("stc_top: unsupported address or data width");
  end
  if (STC_SYNC_STAGES < 2) begin : g_sync_check
    $error("stc_top: reset synchroniser needs at least two stages");
  end
  if (STC_REGIONS != 4) begin : g_region_check
    $error("stc_top: status word carries exactly four clock regions");
  end

  // control register, bus response, override and reset state
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic follow_reg, follow_next;
  logic [STC_REGIONS-1:0] region_en_reg, region_en_next;
  logic [STC_SYNC_STAGES-1:0] rst_sync_reg, rst_sync_next;
  logic int_rst_reg, int_rst_next;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic setup_phase, access_done, ctrl_hit, status_hit;

  // carrier between the control logic and the ram pipeline
  stc_ram_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) ram_bus ();

  // request path into the ram pipeline; software may stop new accesses
  assign ram_bus.req = ram_req && ctrl_reg[STC_CTRL_RAM_EN_BIT];
  assign ram_bus.addr = ram_set_addr_in;
  assign ram_bus.wdata = ram_wdata_in;
  assign ram_bus.scan_mode = scan_mode_select;
  assign ram_bus.ram_hold = ram_select_hold;
  assign ram_bus.mcp_hold = multicycle_ram_hold;

  // set address and write data pipeline
  stc_ram_pipe u_pipe (
    .pclk(pclk),
    .presetn(presetn),
    .ram(ram_bus)
  );

  // apb decode: answer one cycle after setup, in the first access cycle
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign ctrl_hit = (paddr == STC_CTRL_OFFSET);
  assign status_hit = (paddr == STC_STATUS_OFFSET);

  // live block state as seen by software
  always_comb begin
    status_word = '0;
    status_word[STC_ST_REGION_LSB +: STC_REGIONS] = region_en_reg;
    status_word[STC_ST_BUSY_BIT] = ram_bus.busy;
    status_word[STC_ST_RST_BIT] = int_rst_reg;
    status_word[STC_ST_TEST_LSB +: 10] = {scan_mode_select, scan_shift_enable, reset_disable,
                                          multicycle_ram_hold, ram_select_hold,
                                          region_clock_disable, cache_ram_clock_bypass};
  end

  // read data chosen by address; unmapped reads return zero
  always_comb begin
    case (paddr)
      STC_CTRL_OFFSET: read_word = ctrl_reg;
      STC_STATUS_OFFSET: read_word = status_word;
      default: read_word = '0;
    endcase
  end

  // apb response next values; the answer comes in the first access cycle
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      pready_next = 1'b1;
      pslverr_next = !(ctrl_hit || status_hit) || (status_hit && pwrite);
      prdata_next = pwrite ? 32'h00000000 : read_word;
    end else if (psel && penable && !pready_reg) begin
      pready_next = 1'b1;
    end
  end

  // apb response registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // control register: a write lands at the edge that completes the access
  always_comb begin
    ctrl_next = ctrl_reg;
    if (access_done && pwrite && ctrl_hit) begin
      ctrl_next = pwdata & STC_CTRL_WMASK;
    end
  end

  // control register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= STC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // clock region enables: functional gating, shift force-on, region disable
  always_comb begin
    follow_next = cache_ram_clock_bypass;
    for (int i = 0; i < STC_REGIONS; i++) begin
      region_en_next[i] = (region_clock_request[i] && ctrl_reg[STC_CTRL_REGION_LSB + i])
                          || scan_shift_enable;
      if (scan_shift_enable && region_clock_disable[i]) begin
        region_en_next[i] = 1'b0;
      end
    end
  end

  // bypass and region enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      follow_reg <= 1'b0;
      region_en_reg <= '0;
    end else begin
      follow_reg <= follow_next;
      region_en_reg <= region_en_next;
    end
  end

  // reset synchroniser; only the last stage is looked at
  always_comb begin
    rst_sync_next = {rst_sync_reg[STC_SYNC_STAGES-2:0], 1'b1};
  end

  // synchroniser stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= rst_sync_next;
    end
  end

  // blocked reset keeps the internal reset released from the first edge after presetn rises
  always_comb begin
    int_rst_next = rst_sync_reg[STC_SYNC_STAGES-1] || reset_disable;
  end

  // internal reset register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_rst_reg <= 1'b0;
    end else begin
      int_rst_reg <= int_rst_next;
    end
  end

  // outputs straight from the registers
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ram_clock_follow_main = follow_reg;
  assign region_clock_en = region_en_reg;
  assign internal_rst_n = int_rst_reg;
  assign ram_clock_en = ram_bus.ram_clk_en;
  assign ram_chip_select = ram_bus.ram_cs;
  assign ram_set_addr = ram_bus.addr_q;
  assign ram_wdata = ram_bus.wdata_q;
  assign ram_busy = ram_bus.busy;
endmodule

/* common/stc_pkg.sv */
package stc_pkg;
  localparam int STC_REGIONS = 4;
  localparam int STC_SYNC_STAGES = 2;
  localparam logic [11:0] STC_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STC_STATUS_OFFSET = 12'h004;
  localparam logic [31:0] STC_CTRL_RESET = 32'h0000001F;
  localparam int STC_CTRL_REGION_LSB = 0;
  localparam int STC_CTRL_RAM_EN_BIT = 4;
  localparam int STC_ST_REGION_LSB = 0;
  localparam int STC_ST_BUSY_BIT = 4;
  localparam int STC_ST_RST_BIT = 5;
  localparam int STC_ST_TEST_LSB = 6;
  localparam logic [31:0] STC_CTRL_WMASK = 32'h0000001F;
  typedef enum logic [0:0] {STC_ST_IDLE, STC_ST_ACCESS} stc_pipe_state_t;
endpackage

/* common/stc_ram_if.sv */
`timescale 1ns/1ps
// request from the control logic to the ram input pipeline
interface stc_ram_if #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 64
);
  logic req;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic scan_mode;
  logic ram_hold;
  logic mcp_hold;
  logic ram_clk_en;
  logic ram_cs;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic busy;
  modport ctrl (output req, addr, wdata, scan_mode, ram_hold, mcp_hold,
                input ram_clk_en, ram_cs, addr_q, wdata_q, busy);
  modport pipe (input req, addr, wdata, scan_mode, ram_hold, mcp_hold,
                output ram_clk_en, ram_cs, addr_q, wdata_q, busy);
endinterface

/* src/stc_ram_pipe.sv */
`timescale 1ns/1ps
// set address and write data pipeline in front of the cache and snoop filter rams
module stc_ram_pipe
  import stc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  stc_ram_if.pipe ram
);
  stc_pipe_state_t state_reg, state_next;
  logic load_en;
  logic clk_en_next, cs_next;
  logic [$bits(ram.addr)-1:0] addr_reg, addr_next;
  logic [$bits(ram.wdata)-1:0] wdata_reg, wdata_next;
  logic clk_en_reg, cs_reg;

  // load only the cycle before the access, never while the ram clock runs
  always_comb begin
    load_en = ram.req && (state_reg == STC_ST_IDLE);
    if (ram.scan_mode && clk_en_reg) begin
      load_en = 1'b0;
    end
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    state_next = state_reg;
    clk_en_next = 1'b0;
    cs_next = 1'b0;
    if (load_en) begin
      addr_next = ram.addr;
      wdata_next = ram.wdata;
    end
    case (state_reg)
      STC_ST_IDLE: begin
        if (load_en) begin
          state_next = STC_ST_ACCESS;
          clk_en_next = !ram.mcp_hold;
          cs_next = !ram.ram_hold;
        end
      end
      STC_ST_ACCESS: begin
        state_next = STC_ST_IDLE;
      end
      default: state_next = STC_ST_IDLE;
    endcase
  end

  // pipeline registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= STC_ST_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      clk_en_reg <= 1'b0;
      cs_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      clk_en_reg <= clk_en_next;
      cs_reg <= cs_next;
    end
  end

  // ram side outputs straight from the registers
  assign ram.ram_clk_en = clk_en_reg;
  assign ram.ram_cs = cs_reg;
  assign ram.addr_q = addr_reg;
  assign ram.wdata_q = wdata_reg;
  assign ram.busy = (state_reg == STC_ST_ACCESS);
endmodule

/* verification/stc_scan_model.sv */
`timescale 1ns/1ps
// external scan controller: applies an override pattern just after each edge
module stc_scan_model (
  input wire logic pclk,
  input wire logic test_on,
  input wire logic [9:0] pattern,
  output logic cache_ram_clock_bypass,
  output logic [3:0] region_clock_disable,
  output logic ram_select_hold,
  output logic multicycle_ram_hold,
  output logic reset_disable,
  output logic scan_shift_enable,
  output logic scan_mode_select
);
  logic [9:0] drive_reg = 10'h000;
  // outside test every override stays low
  always @(posedge pclk) begin
    drive_reg <= test_on ? pattern : 10'h000;
  end
  assign {scan_mode_select, scan_shift_enable, reset_disable, multicycle_ram_hold, ram_select_hold,
          region_clock_disable, cache_ram_clock_bypass} = drive_reg;
endmodule

/* verification/stc_top_properties.sv */
`timescale 1ns/1ps
module stc_top_properties
  import stc_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cache_ram_clock_bypass,
  input wire logic [STC_REGIONS-1:0] region_clock_disable,
  input wire logic ram_select_hold,
  input wire logic multicycle_ram_hold,
  input wire logic reset_disable,
  input wire logic scan_shift_enable,
  input wire logic scan_mode_select,
  input wire logic ram_clock_follow_main,
  input wire logic [STC_REGIONS-1:0] region_clock_en,
  input wire logic internal_rst_n,
  input wire logic ram_clock_en,
  input wire logic ram_chip_select,
  input wire logic [ADDR_W-1:0] ram_set_addr,
  input wire logic [DATA_W-1:0] ram_wdata,
  input wire logic ram_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ram inputs move, or stay put
  sequence load_s;
    $changed(ram_set_addr) || $changed(ram_wdata);
  endsequence
  sequence held_s;
    $stable(ram_set_addr) && $stable(ram_wdata);
  endsequence
  bypass_follow_a: assert property ($past(presetn) |-> ram_clock_follow_main == $past(cache_ram_clock_bypass))
    else $error("ram clock bypass not followed");
  region_off_a: assert property ($past(presetn && scan_shift_enable) |->
    (region_clock_en & $past(region_clock_disable)) == 4'h0) else $error("disabled region clock on");
  grids_on_a: assert property ($past(presetn && scan_shift_enable) |->
    (region_clock_en | $past(region_clock_disable)) == 4'hF) else $error("clock grid not forced on");
  select_hold_a: assert property (ram_select_hold |=> !ram_chip_select)
    else $error("chip select during hold");
  mcp_hold_a: assert property (multicycle_ram_hold |=> !ram_clock_en) else $error("multicycle ram clocked");
  rst_block_a: assert property ($past(presetn && reset_disable) |-> internal_rst_n)
    else $error("reset not blocked");
  load_gate_a: assert property (load_s |-> ram_busy) else $error("ram inputs moved outside load");
  access_hold_a: assert property (ram_busy |=> held_s ##0 !ram_busy)
    else $error("ram inputs moved in access");
  scan_hold_a: assert property (scan_mode_select && ram_clock_en |=> held_s)
    else $error("load enable in scan");
endmodule
bind stc_top stc_top_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_props (.pclk, .presetn,
  .cache_ram_clock_bypass, .region_clock_disable, .ram_select_hold, .multicycle_ram_hold, .reset_disable,
  .scan_shift_enable, .scan_mode_select, .ram_clock_follow_main, .region_clock_en, .internal_rst_n,
  .ram_clock_en, .ram_chip_select, .ram_set_addr, .ram_wdata, .ram_busy);

/* verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import stc_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, ram_req = '0, test_on = '0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, ctrl;
  logic pready, pslverr, ram_clock_follow_main, internal_rst_n, ram_clock_en, ram_chip_select, ram_busy;
  logic cache_ram_clock_bypass, ram_select_hold, multicycle_ram_hold, reset_disable, scan_shift_enable;
  logic scan_mode_select;
  logic [3:0] region_clock_disable, region_clock_en, region_clock_request = '0;
  logic [9:0] pat = '0, p;
  logic [15:0] ram_set_addr_in = '0, ram_set_addr, a;
  logic [63:0] ram_wdata_in = '0, ram_wdata, w;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  always #5 pclk = ~pclk;
  stc_scan_model u_scan (.pclk, .test_on, .pattern(pat), .cache_ram_clock_bypass, .region_clock_disable,
    .ram_select_hold, .multicycle_ram_hold, .reset_disable, .scan_shift_enable, .scan_mode_select);
  stc_top i_stc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cache_ram_clock_bypass, .region_clock_disable, .ram_select_hold, .multicycle_ram_hold, .reset_disable,
    .scan_shift_enable, .scan_mode_select, .region_clock_request, .ram_req, .ram_set_addr_in, .ram_wdata_in,
    .ram_clock_follow_main, .region_clock_en, .internal_rst_n, .ram_clock_en, .ram_chip_select,
    .ram_set_addr, .ram_wdata, .ram_busy);
  // expected region enables from the override pattern
  function automatic logic [3:0] exp_region(logic [9:0] q, logic [3:0] r, logic [31:0] c);
    return q[8] ? ~q[4:1] : (r & c[3:0]);
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // one apb transfer, result left in rd and err
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // load, then retry with new values during the access cycle
  task automatic ram_access();
    @(posedge pclk);
    ram_req <= 1'b1;
    a = 16'($urandom);
    w = {$urandom, $urandom};
    ram_set_addr_in <= a;
    ram_wdata_in <= w;
    @(posedge pclk);
    ram_req <= 1'b1;
    ram_set_addr_in <= ~a;
    ram_wdata_in <= ~w;
    #1;
    `CHK("busy", 1'b1, ram_busy)
    `CHK("addr", a, ram_set_addr)
    `CHK("wdata", w, ram_wdata)
    `CHK("clk_en", !p[6], ram_clock_en)
    `CHK("cs", !p[5], ram_chip_select)
    @(posedge pclk);
    ram_req <= 1'b0;
    #1;
    `CHK("addr held", a, ram_set_addr)
    `CHK("wdata held", w, ram_wdata)
    `CHK("idle", 1'b0, ram_busy)
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(63));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STC_CTRL_OFFSET, 32'h0);
    `CHK("ctrl reset", STC_CTRL_RESET, rd)
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, STC_STATUS_OFFSET, 32'hFFFFFFFF);
    `CHK("status write err", 1'b1, err)
    $display("test registers done");
    for (int i = 0; i < 40; i++) begin
      ctrl = ($urandom & 32'h0000000F) | 32'h00000010;
      apb(1'b1, STC_CTRL_OFFSET, ctrl);
      test_on <= (i % 4 != 0);
      pat <= (i == 1) ? 10'h3FF : (i == 2) ? 10'h100 : 10'($urandom);
      region_clock_request <= 4'($urandom);
      repeat (4) @(posedge pclk);
      #1;
      p = test_on ? pat : 10'h000;
      `CHK("follow", p[0], ram_clock_follow_main)
      `CHK("region", exp_region(p, region_clock_request, ctrl), region_clock_en)
      apb(1'b0, STC_STATUS_OFFSET, 32'h0);
      `CHK("status", {p, 1'b1, 1'b0, exp_region(p, region_clock_request, ctrl)}, rd[15:0])
      ram_access();
    end
    $display("test overrides done");
    for (int r = 0; r < 2; r++) begin
      test_on <= 1'b1;
      pat <= r ? 10'h080 : 10'h000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      `CHK("rst early", 1'(r), internal_rst_n)
      repeat (2) @(posedge pclk);
      #1;
      `CHK("rst late", 1'b1, internal_rst_n)
    end
    $display("test reset done");
    wrap_up();
  end
endmodule
